// ===== sim/process_scheduler_test.sv
// self-checking bench for the process scheduler and map decode
`timescale 1ns/1ps

module process_scheduler_test;
  import sched_pkg::*;
  localparam int TS = 16;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [5:0] pls = 6'h00;
  logic ready_i, block_i, desched_point_i, check_fail_i;
  logic error_clear_i, event_take_i;
  logic [2:0] ready_id_i = 3'h0;
  logic ready_pri_i = 1'b0;
  logic halt_on_error_i = 1'b0;
  logic boot_from_rom_i = 1'b0;
  logic event_request_i = 1'b0;
  addr_t addr_i = 16'h0000;
  logic run_valid_o, run_pri_o, halted_o, error_o, slice_due_o;
  logic [2:0] run_id_o;
  addr_t boot_addr_o;
  logic event_acknowledge_o, event_ready_o, onchip_o, external_o;
  logic reserved_o, link_out_o, link_in_o, event_chan_o, aligned_o;
  logic [14:0] word_off_o;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;

  // one-cycle request strobes share a single driver vector
  assign {ready_i, block_i, desched_point_i} = pls[5:3];
  assign {check_fail_i, error_clear_i, event_take_i} = pls[2:0];

  process_scheduler #(.PROCS(8), .IDW(3), .TSLICE_CYC(TS))
    process_scheduler_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .ready_i(ready_i), .ready_id_i(ready_id_i), .ready_pri_i(ready_pri_i),
    .block_i(block_i), .desched_point_i(desched_point_i),
    .check_fail_i(check_fail_i), .error_clear_i(error_clear_i),
    .halt_on_error_i(halt_on_error_i), .boot_from_rom_i(boot_from_rom_i),
    .event_request_i(event_request_i), .event_take_i(event_take_i),
    .addr_i(addr_i), .run_valid_o(run_valid_o), .run_id_o(run_id_o),
    .run_pri_o(run_pri_o), .halted_o(halted_o), .error_o(error_o),
    .slice_due_o(slice_due_o), .boot_addr_o(boot_addr_o),
    .event_acknowledge_o(event_acknowledge_o),
    .event_ready_o(event_ready_o), .onchip_o(onchip_o),
    .external_o(external_o), .reserved_o(reserved_o),
    .link_out_o(link_out_o), .link_in_o(link_in_o),
    .event_chan_o(event_chan_o), .aligned_o(aligned_o),
    .word_off_o(word_off_o));

  always #12.5 ref_clk_i = ~ref_clk_i;

  task automatic summarize();
    if (mismatches == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // the whole run needs well under a thousand cycles
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // leaves us just past the n-th rising edge, where outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic pulse(input logic [5:0] m, input logic [2:0] id,
                       input logic pri);
    @(posedge ref_clk_i);
    pls <= m;
    ready_id_i <= id;
    ready_pri_i <= pri;
    @(posedge ref_clk_i);
    pls <= 6'h00;
    #1;
  endtask

  task automatic do_reset(input logic rom, input logic hoe);
    @(posedge ref_clk_i);
    reset_i <= 1'b1;
    boot_from_rom_i <= rom;
    halt_on_error_i <= hoe;
    cyc(10);
    chk("ext_rst", 16'h0001, 16'(external_o));
    chk("boot_rst", 16'h8024, boot_addr_o);
    chk("pri_rst", 16'h0001, 16'(run_pri_o));
    @(posedge ref_clk_i);
    reset_i <= 1'b0;
    cyc(2);
    chk("boot_valid", 16'h0001, 16'(run_valid_o));
    chk("boot_id", 16'h0000, 16'(run_id_o));
    chk("boot_pri", 16'h0001, 16'(run_pri_o));
    chk("boot_addr", rom ? 16'h7FFE : 16'h8024, boot_addr_o);
  endtask

  function automatic logic [6:0] dec(input addr_t a);
    logic on;
    on = a >= 16'h8000 && a <= 16'h87FF;
    return {on, !on, on && a < 16'h8024, on && a < 16'h8008,
            on && a >= 16'h8008 && a < 16'h8010,
            on && a[15:1] == 15'h4008, !a[0]};
  endfunction

  task automatic hi_wake(input logic [2:0] id, input logic err);
    pulse(6'h20, id, 1'b0);
    cyc(18);
    chk("wake_gap", 16'h0000, 16'(run_valid_o));
    chk("err_kept", 16'(err), 16'(error_o));
    cyc(1);
    chk("hi_valid", 16'h0001, 16'(run_valid_o));
    chk("hi_id", 16'(id), 16'(run_id_o));
    chk("hi_pri", 16'h0000, 16'(run_pri_o));
  endtask

  task automatic event_run();
    @(posedge ref_clk_i);
    event_request_i <= 1'b1;
    cyc(1);
    chk("ev_ack", 16'h0001, 16'(event_acknowledge_o));
    chk("ev_ready", 16'h0001, 16'(event_ready_o));
    cyc(3);
    chk("ev_ack_once", 16'h0000, 16'(event_acknowledge_o));
    chk("ev_hold", 16'h0001, 16'(event_ready_o));
    pulse(6'h01, 3'h0, 1'b0);
    cyc(1);
    chk("ev_taken", 16'h0000, 16'(event_ready_o));
    @(posedge ref_clk_i);
    event_request_i <= 1'b0;
  endtask

  initial begin
    static addr_t corner [15] = '{16'h8000, 16'h8006, 16'h8007, 16'h8008,
      16'h800E, 16'h8010, 16'h8011, 16'h8012, 16'h8023, 16'h8024,
      16'h8800, 16'h87FF, 16'h7FFE, 16'h0000, 16'hFFFF};
    addr_t a;
    logic [6:0] seen;
    logic [15:0] ex;
    logic [2:0] hid;
    int n;
    void'($urandom(23));
    do_reset(1'b1, 1'b0);
    for (int i = 0; i < 40; i++) begin
      a = (i < 15) ? corner[i] : (i % 2) ?
          16'(16'h8000 + $urandom % 16'h0900) : 16'($urandom);
      @(posedge ref_clk_i);
      addr_i <= a;
      cyc(2);
      seen = {onchip_o, external_o, reserved_o, link_out_o, link_in_o,
              event_chan_o, aligned_o};
      chk("decode", 16'(dec(a)), 16'(seen));
      if (a >= 16'h8000 && a <= 16'h87FF) begin
        ex = (a - 16'h8000) >> 1;
        chk("word_off", ex, 16'(word_off_o));
      end
    end
    // error set at low level, then pre-empted by a random high process
    pulse(6'h04, 3'h0, 1'b0);
    cyc(1);
    chk("err_set", 16'h0001, 16'(error_o));
    // high ids stay clear of the queued low id 5
    hid = 3'(1 + $urandom % 4);
    hi_wake(hid, 1'b1);
    pulse(6'h02, 3'h0, 1'b0);
    cyc(1);
    chk("err_live", 16'h0000, 16'(error_o));
    pulse(6'h20, 3'h5, 1'b1);
    cyc(3 * TS);
    chk("hi_keeps", 16'(hid), 16'(run_id_o));
    chk("hi_over_lo", 16'h0000, 16'(run_pri_o));
    pulse(6'h10, 3'h0, 1'b0);
    cyc(1);
    chk("resume_id", 16'h0000, 16'(run_id_o));
    chk("resume_pri", 16'h0001, 16'(run_pri_o));
    chk("err_restore", 16'h0001, 16'(error_o));
    event_run();
    // round robin of two low processes
    do_reset(1'b0, 1'b0);
    pulse(6'h20, 3'h5, 1'b1);
    pulse(6'h08, 3'h0, 1'b0);
    cyc(1);
    chk("early_desched", 16'h0000, 16'(run_id_o));
    for (int k = 0; k < 3; k++) begin
      n = 0;
      while (slice_due_o !== 1'b1 && n < 3 * TS) begin
        cyc(1);
        n++;
      end
      ex = 16'(n >= TS - 4 && n <= 2 * TS + 2);
      chk("slice_len", 16'h0001, ex);
      ex = (k % 2) ? 16'h0005 : 16'h0000;
      chk("no_switch", ex, 16'(run_id_o));
      pulse(6'h08, 3'h0, 1'b0);
      cyc(1);
      chk("next_low", ex ^ 16'h0005, 16'(run_id_o));
      chk("slice_new", 16'h0000, 16'(slice_due_o));
    end
    // draining the low queue by blocks leaves the processor idle
    pulse(6'h10, 3'h0, 1'b0);
    cyc(1);
    chk("block_next", 16'h0000, 16'(run_id_o));
    pulse(6'h10, 3'h0, 1'b0);
    cyc(1);
    chk("idle", 16'h0000, 16'(run_valid_o));
    pulse(6'h20, 3'h6, 1'b1);
    cyc(1);
    chk("idle_start", 16'h0006, 16'(run_id_o));
    chk("idle_valid", 16'h0001, 16'(run_valid_o));
    // halt mode strapped at boot
    do_reset(1'b1, 1'b1);
    pulse(6'h04, 3'h0, 1'b0);
    n = 0;
    while (halted_o !== 1'b1 && n < 4) begin
      cyc(1);
      n++;
    end
    chk("halted", 16'h0001, 16'(halted_o));
    chk("err_pin", 16'h0001, 16'(error_o));
    pulse(6'h20, 3'h3, 1'b0);
    cyc(20);
    chk("halt_stays", 16'h0001, 16'(halted_o));
    chk("halt_norun", 16'h0000, 16'(run_valid_o));
    event_run();
    summarize();
  end
endmodule // process_scheduler_test

// ===== src/process_scheduler.sv
// two-level process scheduler with error flag and memory map decode
// Behaviour
// - two levels, 0 high, 1 low; low dispatched only with no high ready
// - a high process keeps the processor until it blocks or ends
// - low work is timesliced every 5120 input clock cycles
// - low start within 2n-2 slices; runs one to two slices
// - high wake on channel ready takes 19 cycles, at most 53
// - a failed runtime check sets the error flag; error pin follows it
// - a mode picked at start-up halts execution on error
// - after an error halt links finish and the device stays analysable
// - error saved on pre-emption, restored when high work is done
// - signed byte address space, two-byte words, base most negative
// - #8000 to #87FF is on-chip RAM, external memory from #8800
// - lowest 18 words reserved; first free byte address #8024
// - link outputs #8000-#8006, inputs #8008-#800E, event #8010
// - boot from ROM starts at byte address #7FFE
// - event request rise is acknowledged and readies event word 8
`timescale 1ns/1ps
`include "sched_map.svh"

module process_scheduler #(
  parameter int PROCS = 8,
  parameter int IDW = 3,
  parameter int TSLICE_CYC = `TSLICE_CYC
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic ready_i,
  input wire logic [IDW-1:0] ready_id_i,
  input wire logic ready_pri_i,
  input wire logic block_i,
  input wire logic desched_point_i,
  input wire logic check_fail_i,
  input wire logic error_clear_i,
  input wire logic halt_on_error_i,
  input wire logic boot_from_rom_i,
  input wire logic event_request_i,
  input wire logic event_take_i,
  input wire sched_pkg::addr_t addr_i,
  output logic run_valid_o,
  output logic [IDW-1:0] run_id_o,
  output logic run_pri_o,
  output logic halted_o,
  output logic error_o,
  output logic slice_due_o,
  output sched_pkg::addr_t boot_addr_o,
  output logic event_acknowledge_o,
  output logic event_ready_o,
  output logic onchip_o,
  output logic external_o,
  output logic reserved_o,
  output logic link_out_o,
  output logic link_in_o,
  output logic event_chan_o,
  output logic aligned_o,
  output logic [14:0] word_off_o
);
  import sched_pkg::*;

  localparam int LAT_MAX_I = `INT_LAT_MAX;
  localparam logic [12:0] TICK_LAST = 13'(TSLICE_CYC - 1);

  sched_state_t state_ff, nxt_state;
  logic [IDW-1:0] run_id_ff, nxt_run_id, pre_id_ff, nxt_pre_id;
  logic pre_vld_ff, nxt_pre_vld;
  logic err_ff, saved_err_ff, halt_mode_ff;
  addr_t boot_addr_ff;
  logic run_valid_ff, run_pri_ff, halted_ff, slice_due_ff, external_ff;
  logic [12:0] tick_cnt_ff;
  logic [1:0] slice_ff;
  logic [5:0] wake_cnt_ff;
  logic req_d_ff, ack_ff, ev_rdy_ff;
  logic onchip_ff, reserved_ff, link_out_ff, link_in_ff, event_ff;
  logic aligned_ff;
  logic [14:0] word_off_ff;

  // per-level ready queues; level 1 also takes the expired low process
  logic [1:0] q_empty, push0, push1, pop;
  logic [IDW-1:0] head [2];
  logic requeue, save_err, restore_err;

  assign push0[0] = ready_i && (ready_pri_i == `PRI_HI);
  assign push0[1] = ready_i && (ready_pri_i == `PRI_LO);
  assign push1[0] = 1'b0;
  assign push1[1] = requeue;

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_queue
      logic [IDW-1:0] mem [PROCS];
      logic [IDW-1:0] wr_ff, rd_ff;
      logic [IDW:0] cnt_ff;
      wire [IDW-1:0] wr_alt = wr_ff + IDW'(push0[p]);
      always_ff @(posedge ref_clk_i) begin
        if (push0[p]) mem[wr_ff] <= ready_id_i;
        if (push1[p]) mem[wr_alt] <= run_id_ff;
      end
      always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
          wr_ff <= '0;
          rd_ff <= '0;
          cnt_ff <= '0;
        end else begin
          wr_ff <= wr_alt + IDW'(push1[p]);
          rd_ff <= rd_ff + IDW'(pop[p]);
          cnt_ff <= cnt_ff + (IDW+1)'(push0[p]) + (IDW+1)'(push1[p])
                    - (IDW+1)'(pop[p]);
        end
      end
      assign head[p] = mem[rd_ff];
      assign q_empty[p] = (cnt_ff == '0);
    end
  endgenerate

  wire hi_rdy = !q_empty[0];
  wire lo_rdy = !q_empty[1];
  wire tick = (tick_cnt_ff == TICK_LAST);
  wire expired = (slice_ff == `SLICE_LIMIT);
  wire halt_now = halt_mode_ff && err_ff && (state_ff != ST_BOOT);
  wire wake_done = (wake_cnt_ff == 6'(`WAKE_LAST));
  wire lo_active = (state_ff == ST_RUN_LO) || pre_vld_ff;
  wire slice_clr = pop[1]
                   || (state_ff == ST_RUN_LO && nxt_run_id != run_id_ff);
  wire slice_inc = tick && lo_active && !expired;
  wire [1:0] nxt_slice = slice_clr ? 2'h0 : slice_ff + 2'(slice_inc);

  always_comb begin
    nxt_state = state_ff;
    nxt_run_id = run_id_ff;
    nxt_pre_id = pre_id_ff;
    nxt_pre_vld = pre_vld_ff;
    pop = 2'b00;
    requeue = 1'b0;
    save_err = 1'b0;
    restore_err = 1'b0;
    if (halt_now) begin
      nxt_state = ST_HALT;
    end else begin
      case (state_ff)
        ST_BOOT: begin
          nxt_run_id = IDW'(`BOOT_PROC_ID);
          nxt_state = ST_RUN_LO;
        end
        ST_IDLE: begin
          if (hi_rdy) begin
            nxt_state = ST_WAKE;
          end else if (lo_rdy) begin
            pop[1] = 1'b1;
            nxt_run_id = head[1];
            nxt_state = ST_RUN_LO;
          end
        end
        ST_WAKE: begin
          if (wake_done) begin
            pop[0] = 1'b1;
            nxt_run_id = head[0];
            nxt_state = ST_RUN_HI;
          end
        end
        ST_RUN_HI: begin
          // no slice check here: high work runs until it blocks
          if (block_i) begin
            if (hi_rdy) begin
              pop[0] = 1'b1;
              nxt_run_id = head[0];
            end else if (pre_vld_ff) begin
              restore_err = 1'b1;
              nxt_pre_vld = 1'b0;
              nxt_run_id = pre_id_ff;
              nxt_state = ST_RUN_LO;
            end else if (lo_rdy) begin
              pop[1] = 1'b1;
              nxt_run_id = head[1];
              nxt_state = ST_RUN_LO;
            end else begin
              nxt_state = ST_IDLE;
            end
          end
        end
        ST_RUN_LO: begin
          if (hi_rdy) begin
            save_err = 1'b1;
            nxt_pre_vld = 1'b1;
            nxt_pre_id = run_id_ff;
            nxt_state = ST_WAKE;
          end else if (block_i) begin
            if (lo_rdy) begin
              pop[1] = 1'b1;
              nxt_run_id = head[1];
            end else begin
              nxt_state = ST_IDLE;
            end
          end else if (expired && desched_point_i && lo_rdy) begin
            requeue = 1'b1;
            pop[1] = 1'b1;
            nxt_run_id = head[1];
          end
        end
        // links are outside and keep running; state stays for analysis
        ST_HALT: nxt_state = ST_HALT;
        default: nxt_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_ff <= ST_BOOT;
      run_id_ff <= '0;
      pre_id_ff <= '0;
      pre_vld_ff <= 1'b0;
      run_valid_ff <= 1'b0;
      run_pri_ff <= `PRI_LO;
      halted_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      run_id_ff <= nxt_run_id;
      pre_id_ff <= nxt_pre_id;
      pre_vld_ff <= nxt_pre_vld;
      run_valid_ff <= (nxt_state == ST_RUN_HI) || (nxt_state == ST_RUN_LO);
      run_pri_ff <= (nxt_state == ST_RUN_HI) ? `PRI_HI : `PRI_LO;
      halted_ff <= (nxt_state == ST_HALT);
    end
  end

  // slice ticks run free; a low process that is resumed keeps its count,
  // so time taken by high work comes out of its share
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tick_cnt_ff <= '0;
      slice_ff <= '0;
      slice_due_ff <= 1'b0;
      wake_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= tick ? '0 : tick_cnt_ff + 13'h0001;
      slice_ff <= nxt_slice;
      slice_due_ff <= (nxt_slice == `SLICE_LIMIT);
      wake_cnt_ff <= (state_ff == ST_WAKE) ? wake_cnt_ff + 6'h01 : '0;
    end
  end

  // a failure in the same cycle as a clear or a restore still sets the flag
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      err_ff <= 1'b0;
      saved_err_ff <= 1'b0;
    end else begin
      err_ff <= (restore_err ? saved_err_ff : (err_ff & ~error_clear_i))
                | check_fail_i;
      if (save_err)
        saved_err_ff <= err_ff;
    end
  end

  // straps are caught in the boot cycle, after reset has released
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      halt_mode_ff <= 1'b0;
      boot_addr_ff <= `MEMSTART;
    end else if (state_ff == ST_BOOT) begin
      halt_mode_ff <= halt_on_error_i;
      boot_addr_ff <= boot_from_rom_i ? `BOOT_VECTOR : `MEMSTART;
    end
  end

  wire ev_rise = event_request_i && !req_d_ff;
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      req_d_ff <= 1'b0;
      ack_ff <= 1'b0;
      ev_rdy_ff <= 1'b0;
    end else begin
      req_d_ff <= event_request_i;
      ack_ff <= ev_rise;
      ev_rdy_ff <= ev_rise | (ev_rdy_ff & ~event_take_i);
    end
  end

  // flipping the sign bit turns the signed address into a word index
  wire [14:0] w_off = 15'((addr_i ^ `ONCHIP_BASE) >> 1);
  wire in_ram = (addr_i >= `ONCHIP_BASE) && (addr_i <= `ONCHIP_TOP);
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      onchip_ff <= 1'b0;
      external_ff <= 1'b1;
      reserved_ff <= 1'b0;
      link_out_ff <= 1'b0;
      link_in_ff <= 1'b0;
      event_ff <= 1'b0;
      aligned_ff <= 1'b0;
      word_off_ff <= '0;
    end else begin
      onchip_ff <= in_ram;
      external_ff <= !in_ram;
      reserved_ff <= in_ram && (w_off < `RESV_WORDS);
      link_out_ff <= in_ram && (w_off < `LINK_IN_WORD);
      link_in_ff <= in_ram && (w_off >= `LINK_IN_WORD)
                    && (w_off < `EVENT_WORD);
      event_ff <= in_ram && (w_off == `EVENT_WORD);
      aligned_ff <= !addr_i[0];
      word_off_ff <= w_off;
    end
  end

  assign run_valid_o = run_valid_ff;
  assign run_id_o = run_id_ff;
  assign run_pri_o = run_pri_ff;
  assign halted_o = halted_ff;
  assign error_o = err_ff;
  assign slice_due_o = slice_due_ff;
  assign boot_addr_o = boot_addr_ff;
  assign event_acknowledge_o = ack_ff;
  assign event_ready_o = ev_rdy_ff;
  assign onchip_o = onchip_ff;
  assign external_o = external_ff;
  assign reserved_o = reserved_ff;
  assign link_out_o = link_out_ff;
  assign link_in_o = link_in_ff;
  assign event_chan_o = event_ff;
  assign aligned_o = aligned_ff;
  assign word_off_o = word_off_ff;

  sequence hi_arrival;
    ready_i && (ready_pri_i == `PRI_HI) && !halt_now && !check_fail_i
    && (state_ff == ST_IDLE || state_ff == ST_RUN_LO) && q_empty[0];
  endsequence
  sequence hi_done_resume;
    state_ff == ST_RUN_HI && block_i && !hi_rdy && pre_vld_ff
    && !halt_now && !check_fail_i;
  endsequence

  chk_low_waits_high: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    pop[1] |-> q_empty[0])
    else $error("low process dispatched while high work ready");
  chk_high_keeps_cpu: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    state_ff == ST_RUN_HI && !block_i && !halt_now
    |=> state_ff == ST_RUN_HI && $stable(run_id_ff))
    else $error("high process lost the processor without blocking");
  chk_slice_period: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    tick |=> tick_cnt_ff == '0 ##1 tick_cnt_ff == 13'h0001)
    else $error("timeslice counter did not wrap at its period");
  chk_slice_share: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    pop[1] |=> slice_ff == '0 && state_ff == ST_RUN_LO)
    else $error("new low process did not start a fresh slice");
  chk_wake_latency: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    hi_arrival |-> ##[1:LAT_MAX_I] (state_ff == ST_RUN_HI
                                    || state_ff == ST_HALT))
    else $error("high wake-up exceeded its latency");
  chk_error_sets: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    check_fail_i |=> error_o)
    else $error("error flag not set by a failed check");
  chk_error_halts: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    halt_now |=> halted_o && !run_valid_o)
    else $error("error did not halt in halt mode");
  chk_halt_holds: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    halted_o |-> pop == 2'b00 ##1 halted_o)
    else $error("halted scheduler still dispatching");
  chk_error_restore: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    hi_done_resume |=> err_ff == $past(saved_err_ff)
                       && run_id_ff == $past(pre_id_ff))
    else $error("pre-empted error state not restored");
  chk_ram_decode: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    addr_i == `EXT_BASE ##1 addr_i == `ONCHIP_TOP
    |-> ##1 onchip_o && $past(external_o))
    else $error("on-chip range boundary decoded wrongly");
  chk_event_ack: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    ev_rise |=> event_acknowledge_o && event_ready_o)
    else $error("event rise not acknowledged");
  chk_requeue_tail: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    requeue |-> expired && desched_point_i ##1 run_id_ff != $past(run_id_ff))
    else $error("expired low process was not rotated");
endmodule // process_scheduler

// ===== src/sched_map.svh
// constants for the process scheduler, error flag and memory map decode
`ifndef SCHED_MAP_SVH
`define SCHED_MAP_SVH
`define PRI_HI 1'b0
`define PRI_LO 1'b1
`define TSLICE_CYC 5120
`define SLICE_LIMIT 2'h2
`define INT_LAT_TYP 19
`define INT_LAT_MAX 53
`define WAKE_LAST (`INT_LAT_TYP - 2)
`define ONCHIP_BASE 16'h8000
`define ONCHIP_TOP 16'h87FF
`define EXT_BASE 16'h8800
`define MEMSTART 16'h8024
`define BOOT_VECTOR 16'h7FFE
`define RESV_WORDS 15'h0012
`define LINK_IN_WORD 15'h0004
`define EVENT_WORD 15'h0008
`define BOOT_PROC_ID 0
`endif

// ===== src/sched_pkg.sv
// types shared by the scheduler design
package sched_pkg;
  typedef enum logic [2:0] {
    ST_BOOT = 3'b000,
    ST_IDLE = 3'b001,
    ST_WAKE = 3'b010,
    ST_RUN_HI = 3'b011,
    ST_RUN_LO = 3'b100,
    ST_HALT = 3'b101
  } sched_state_t;
  typedef logic [15:0] addr_t;
endpackage
